//--- rtl/sow_pkg.sv
// sanitize overwrite package: command codes, field positions, states
// assumes nothing beyond a SystemVerilog compiler
package sow_pkg;
  // ****************
  // command decode
  // ****************
  localparam logic [7:0] SOW_CMD_SANITIZE = 8'h00B4;
  localparam logic [15:0] SOW_FEAT_OVERWRITE = 16'h0014;
  localparam logic [15:0] SOW_FEAT_STATUS = 16'h0000;
  localparam logic [15:0] SOW_FEAT_FREEZE = 16'h0020;
  // ****************
  // sector count fields
  // ****************
  localparam int SOW_SC_INVERT = 7;
  localparam int SOW_SC_FAILMODE = 4;
  localparam int SOW_SC_DONE = 15;
  localparam int SOW_SC_BUSY = 14;
  localparam int SOW_SC_FROZEN = 13;
  // ****************
  // status and error bits
  // ****************
  localparam int SOW_ERR_ABT = 2;
  localparam int SOW_ST_BSY = 7;
  localparam int SOW_ST_RDY = 6;
  localparam int SOW_ST_DSC = 4;
  localparam int SOW_ST_ERR = 0;
  localparam logic [7:0] SOW_ERR_RESET = 8'h0000;
  localparam logic [7:0] SOW_STS_RESET = 8'h0050;
  // ****************
  // reason codes and progress
  // ****************
  localparam logic [7:0] SOW_RSN_NONE = 8'h0000;
  localparam logic [7:0] SOW_RSN_UNSAN = 8'h0001;
  localparam logic [7:0] SOW_RSN_BADFEAT = 8'h0002;
  localparam logic [7:0] SOW_RSN_FROZEN = 8'h0003;
  localparam logic [15:0] SOW_PROG_IDLE = 16'hFFFF;
  localparam logic [4:0] SOW_PASS_ZERO = 5'h0010;
  // ****************
  // sanitize states, gray along the idle-oper-success path
  // ****************
  typedef enum logic [2:0] {
    SOW_IDLE = 3'h0,
    SOW_OPER = 3'h1,
    SOW_SUCC = 3'h3,
    SOW_FAIL = 3'h2,
    SOW_FROZ = 3'h6
  } sow_state_t;
endpackage

//--- rtl/sow_filler.sv
// sow_filler: writes the pattern over all user sectors, pass by pass
// assumes a media port that takes one dword per cycle when ready
`timescale 1ns/1ps
`default_nettype none
module sow_filler
  import sow_pkg::*;
#(
  parameter int LBA_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic start,
  input wire logic [31:0] pattern,
  input wire logic invert,
  input wire logic [4:0] passes,
  input wire logic [LBA_W-1:0] last_lba,
  input wire logic media_ready,
  input wire logic media_err,
  output logic wr_valid,
  output logic [LBA_W-1:0] wr_lba,
  output logic [31:0] wr_data,
  output logic busy,
  output logic done,
  output logic failed,
  output logic [15:0] progress
);
  logic [4:0] pass_r;
  logic [LBA_W-1:0] lba_r;
  logic inv_r;
  logic bad_r;
  wire last_lba_w = (lba_r == last_lba);
  wire last_pass_w = (pass_r == passes - 5'd1);
  wire step_w = busy && media_ready;
  // ****************
  // pass walker
  // ****************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      done <= 1'b0;
      failed <= 1'b0;
      pass_r <= 5'd0;
      lba_r <= '0;
      inv_r <= 1'b0;
      bad_r <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        pass_r <= 5'd0;
        lba_r <= '0;
        inv_r <= 1'b0;
        bad_r <= 1'b0;
      end else if (step_w) begin
        bad_r <= bad_r | media_err;
        lba_r <= last_lba_w ? '0 : lba_r + 1'b1;
        if (last_lba_w) begin
          inv_r <= invert & ~inv_r;
          pass_r <= pass_r + 5'd1;
          if (last_pass_w) begin
            busy <= 1'b0;
            done <= 1'b1;
            failed <= bad_r | media_err;
          end
        end
      end
    end
  end
  assign wr_valid = busy;
  assign wr_lba = lba_r;
  assign wr_data = inv_r ? ~pattern : pattern;
  assign progress = {pass_r[3:0], lba_r[LBA_W-1 -: 8], 4'h0};
endmodule
`default_nettype wire

//--- rtl/sow_top.sv
// sow_top: sanitize overwrite command interpreter on the task file
// assumes the host strobes CMD_GO with task-file values stable that cycle
// Operation
// - opcode B4h with feature 0014h means overwrite
// - start only when supported and idle/failed/succeeded
// - fill whole user area with pattern
// - pattern bytes from previous/current address fields
// - invert option alternates pattern per pass
// - pass count bits 3:0, zero means sixteen
// - failure mode one: status may leave failed
// - failure mode zero: abort failmode requests while failed
// - bit 15 completion flag survives RSTN, cleared by power-on reset or by an accepted overwrite
// - bit 14 shows operation in progress
// - bit 13 shows frozen state
// - progress over 65536, FFFFh when idle
// - successful overwrite leaves blocks readable
// - abort failmode-one request after failmode-zero failure
// - reason code in sector number on error
`timescale 1ns/1ps
`default_nettype none
module sow_top
  import sow_pkg::*;
(
  // clock, reset, enable
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic CE,
  // power-on reset and feature support
  input wire logic POR_N,
  input wire logic SANITIZE_SUPPORTED,
  // task file inputs
  input wire logic CMD_GO,
  input wire logic [7:0] CMD_OP,
  input wire logic [15:0] FEATURE,
  input wire logic [7:0] SECTOR_COUNT,
  input wire logic [7:0] SECNUM_CUR,
  input wire logic [7:0] SECNUM_PREV,
  input wire logic [7:0] CYL_LOW,
  input wire logic [7:0] CYL_HIGH,
  // media port
  input wire logic MEDIA_READY,
  input wire logic MEDIA_ERR,
  output logic MEDIA_WR,
  output logic [7:0] MEDIA_LBA,
  output logic [31:0] MEDIA_DATA,
  // task file outputs
  output logic [7:0] ERROR_OUT,
  output logic [7:0] STATUS_OUT,
  output logic [15:0] SC_OUT,
  output logic [7:0] CYL_LOW_OUT,
  output logic [7:0] SECNUM_OUT,
  output logic CMD_DONE
);
  sow_state_t state_r, state_nxt;
  logic fm_r, fm_nxt;
  logic done_flag_r;
  logic [7:0] command_error_flags_r, command_status_flags_r;
  logic [14:0] sc_r;
  logic [7:0] cl_r, sn_r;
  logic done_r;
  logic [31:0] pat_r;
  logic inv_r;
  logic [4:0] passes_r;
  logic fill_start_r;
  logic f_wr, f_busy, f_done, f_fail;
  logic [7:0] f_lba;
  logic [31:0] f_data;
  logic [15:0] f_prog;
  // ****************
  // decode
  // ****************
  wire is_san_w = CMD_GO && (CMD_OP == SOW_CMD_SANITIZE);
  wire is_ow_w = is_san_w && (FEATURE == SOW_FEAT_OVERWRITE);
  wire is_st_w = is_san_w && (FEATURE == SOW_FEAT_STATUS);
  wire is_fz_w = is_san_w && (FEATURE == SOW_FEAT_FREEZE);
  wire bad_feat_w = is_san_w && !is_ow_w && !is_st_w && !is_fz_w;
  wire req_fm_w = SECTOR_COUNT[SOW_SC_FAILMODE];
  wire state_ok_w = (state_r == SOW_IDLE) || (state_r == SOW_FAIL) ||
                    (state_r == SOW_SUCC);
  wire fm_block_w = (state_r == SOW_FAIL) && !fm_r && req_fm_w;
  wire accept_w = is_ow_w && SANITIZE_SUPPORTED && state_ok_w && !fm_block_w;
  wire reject_w = (is_ow_w && !accept_w) || bad_feat_w ||
                  (is_fz_w && !SANITIZE_SUPPORTED) ||
                  (is_fz_w && state_r == SOW_OPER);
  wire st_ok_w = is_st_w && SANITIZE_SUPPORTED;
  wire [4:0] npass_w = (SECTOR_COUNT[3:0] == 4'h0) ? SOW_PASS_ZERO :
                       {1'b0, SECTOR_COUNT[3:0]};
  wire [31:0] pat_w = {SECNUM_PREV, CYL_HIGH, CYL_LOW, SECNUM_CUR};
  wire [7:0] reason_w = (state_r == SOW_FROZ) ? SOW_RSN_FROZEN :
                        bad_feat_w ? SOW_RSN_BADFEAT :
                        (state_r == SOW_FAIL) ? SOW_RSN_UNSAN : SOW_RSN_NONE;
  wire [15:0] prog_w = (state_nxt == SOW_OPER) ? f_prog : SOW_PROG_IDLE;
  // ****************
  // sanitize state machine
  // ****************
  always_comb begin
    state_nxt = state_r;
    fm_nxt = fm_r;
    case (state_r)
      SOW_IDLE, SOW_SUCC, SOW_FAIL: begin
        if (accept_w) begin
          state_nxt = SOW_OPER;
          fm_nxt = req_fm_w;
        end else if (is_fz_w && SANITIZE_SUPPORTED) begin
          state_nxt = SOW_FROZ;
        end else if (st_ok_w && state_r == SOW_FAIL && fm_r) begin
          state_nxt = SOW_IDLE;
        end
      end
      SOW_OPER: begin
        if (f_done) begin
          state_nxt = f_fail ? SOW_FAIL : SOW_SUCC;
        end
      end
      SOW_FROZ: state_nxt = SOW_FROZ;
      default: state_nxt = SOW_IDLE;
    endcase
  end
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_r <= SOW_IDLE;
      fm_r <= 1'b0;
    end else if (CE) begin
      state_r <= state_nxt;
      fm_r <= fm_nxt;
    end
  end
  // ****************
  // completion flag kept over RSTN, cleared by power-on reset
  // ****************
  always_ff @(posedge SYS_CLK or negedge POR_N) begin
    if (!POR_N) begin
      done_flag_r <= 1'b0;
    end else if (CE) begin
      if (accept_w) begin
        done_flag_r <= 1'b0;
      end else if (f_done && !f_fail) begin
        done_flag_r <= 1'b1;
      end
    end
  end
  // ****************
  // request capture and answers
  // ****************
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pat_r <= 32'h0000_0000;
      inv_r <= 1'b0;
      passes_r <= 5'd0;
      fill_start_r <= 1'b0;
      command_error_flags_r <= SOW_ERR_RESET;
      command_status_flags_r <= SOW_STS_RESET;
      sc_r <= 15'h0000;
      cl_r <= 8'hFF;
      sn_r <= 8'hFF;
      done_r <= 1'b0;
    end else if (CE) begin
      fill_start_r <= accept_w;
      done_r <= reject_w || accept_w || st_ok_w || (is_fz_w && !reject_w);
      sc_r <= {state_nxt == SOW_OPER, state_nxt == SOW_FROZ, 13'h0000};
      {cl_r, sn_r} <= prog_w;
      if (accept_w) begin
        pat_r <= pat_w;
        inv_r <= SECTOR_COUNT[SOW_SC_INVERT];
        passes_r <= npass_w;
      end
      if (reject_w) begin
        command_error_flags_r <= 8'h01 << SOW_ERR_ABT;
        command_status_flags_r <= SOW_STS_RESET | (8'h01 << SOW_ST_ERR);
        sn_r <= reason_w;
      end else if (is_san_w) begin
        command_error_flags_r <= SOW_ERR_RESET;
        command_status_flags_r <= SOW_STS_RESET;
      end
    end
  end
  sow_filler #(.LBA_W(8)) u_fill (
    .clk(SYS_CLK),
    .rst_n(RSTN),
    .ce(CE),
    .start(fill_start_r),
    .pattern(pat_r),
    .invert(inv_r),
    .passes(passes_r),
    .last_lba(8'hFF),
    .media_ready(MEDIA_READY),
    .media_err(MEDIA_ERR),
    .wr_valid(f_wr),
    .wr_lba(f_lba),
    .wr_data(f_data),
    .busy(f_busy),
    .done(f_done),
    .failed(f_fail),
    .progress(f_prog)
  );
  // ****************
  // registered outputs
  // ****************
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      MEDIA_WR <= 1'b0;
      MEDIA_LBA <= 8'h00;
      MEDIA_DATA <= 32'h0000_0000;
    end else if (CE) begin
      MEDIA_WR <= f_wr && MEDIA_READY;
      MEDIA_LBA <= f_lba;
      MEDIA_DATA <= f_data;
    end
  end
  assign ERROR_OUT = command_error_flags_r;
  assign STATUS_OUT = command_status_flags_r;
  // completion bit straight from the flag so it rides through RSTN
  assign SC_OUT = {done_flag_r, sc_r};
  assign CYL_LOW_OUT = cl_r;
  assign SECNUM_OUT = sn_r;
  assign CMD_DONE = done_r;
  // ****************
  // checks
  // ****************
  a_reject_abort: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (CE && reject_w) |=> (ERROR_OUT[SOW_ERR_ABT] && STATUS_OUT[SOW_ST_ERR] &&
    !STATUS_OUT[SOW_ST_BSY] && CMD_DONE)) else $error("reject lacks abort");
  a_accept_state: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (CE && accept_w) |-> (state_r != SOW_OPER && state_r != SOW_FROZ))
    else $error("accept in wrong state");
  a_accept_oper: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (CE && accept_w) |=> (state_r == SOW_OPER && SC_OUT[SOW_SC_BUSY]))
    else $error("busy bit missing");
  a_fm_block: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (state_r == SOW_FAIL && !fm_r && is_ow_w && req_fm_w) |-> !accept_w)
    else $error("failmode request taken");
  a_idle_prog: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (CE && state_r != SOW_OPER && state_nxt != SOW_OPER && !reject_w) |=>
    ({CYL_LOW_OUT, SECNUM_OUT} == SOW_PROG_IDLE)) else $error("idle progress");
  a_frozen_bit: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (CE && state_r == SOW_FROZ) |=> SC_OUT[SOW_SC_FROZEN]) else $error("frozen bit");
  a_pass_cap: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (CE && accept_w && SECTOR_COUNT[3:0] == 4'h0) |=> (passes_r == 5'd16))
    else $error("zero count not sixteen");
  a_pattern_cap: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (CE && accept_w) |=> (pat_r == $past(pat_w))) else $error("pattern bytes");
  a_done_flag: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (CE && f_done && !f_fail) |=> (done_flag_r && state_r == SOW_SUCC))
    else $error("completion flag");
endmodule
`default_nettype wire

//--- verif/sow_media_model.sv
// media port partner: stalls one cycle in 64 writes, fails on demand
// assumes the bench raises fail_en to make the media report errors
`timescale 1ns/1ps
`default_nettype none
module sow_media_model (
  // media port
  input wire logic clk,
  input wire logic wr,
  input wire logic fail_en,
  output logic ready,
  output logic err
);
  logic [5:0] cnt_r = 6'h00;
  // one stall cycle after every 64th write, error level as commanded
  always @(posedge clk) begin
    if (wr === 1'b1) begin
      cnt_r <= cnt_r + 6'h01;
    end
  end
  assign ready = !(wr === 1'b1 && cnt_r == 6'h3F);
  assign err = fail_en;
endmodule
`default_nettype wire

//--- verif/tb.sv
// tb: self-checking bench for the sanitize overwrite interpreter
// assumes sow_top and sow_media_model, 40 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb
  import sow_pkg::*;
;
  logic clk, rstn, por_n, sup, go, fail_en, inv;
  logic [7:0] op, sc, s_cur, s_prev, c_lo, c_hi;
  logic [15:0] feat;
  logic [31:0] pat;
  wire logic ready, err, mwr, done;
  wire logic [7:0] lba, err_o, sts_o, clo_o, sn_o;
  wire logic [31:0] mdata;
  wire logic [15:0] sc_o;
  int bad_count, check_count, wr_n, cyc;
  sow_top u_sow_top (.SYS_CLK(clk), .RSTN(rstn), .CE(1'b1), .POR_N(por_n),
    .SANITIZE_SUPPORTED(sup), .CMD_GO(go), .CMD_OP(op), .FEATURE(feat),
    .SECTOR_COUNT(sc), .SECNUM_CUR(s_cur), .SECNUM_PREV(s_prev), .CYL_LOW(c_lo),
    .CYL_HIGH(c_hi), .MEDIA_READY(ready), .MEDIA_ERR(err), .MEDIA_WR(mwr),
    .MEDIA_LBA(lba), .MEDIA_DATA(mdata), .ERROR_OUT(err_o), .STATUS_OUT(sts_o),
    .SC_OUT(sc_o), .CYL_LOW_OUT(clo_o), .SECNUM_OUT(sn_o), .CMD_DONE(done));
  sow_media_model u_sow_media_model (.clk(clk), .wr(mwr), .fail_en(fail_en),
    .ready(ready), .err(err));
  // ****************
  // helpers
  // ****************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cmd(input logic [15:0] f, input logic [7:0] c);
    @(posedge clk) #2;
    go = 1;
    op = SOW_CMD_SANITIZE;
    feat = f;
    sc = c;
    @(posedge clk) #2;
    go = 0;
    chk("done", 1, done);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 6000 && sc_o[14] !== 1'b0; i++) begin
      @(posedge clk) #2;
    end
  endtask
  task automatic rej(input logic [15:0] f, input logic [7:0] c, input logic [7:0] why);
    cmd(f, c);
    chk("error", 8'h04, err_o);
    chk("status", 8'h51, sts_o);
    chk("reason", why, sn_o);
    chk("busy", 0, sc_o[14]);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic run(input logic [7:0] c, input int n);
    wr_n = 0;
    inv = c[7];
    cmd(SOW_FEAT_OVERWRITE, c);
    chk("busy", 1, sc_o[14]);
    chk("flag", 0, sc_o[15]);
    repeat (100) @(posedge clk);
    #2;
    chk("prog", 1, {clo_o, sn_o} != SOW_PROG_IDLE);
    wait_idle();
    chk("writes", n, wr_n);
    chk("flag", 1, sc_o[15]);
    chk("prog", SOW_PROG_IDLE, {clo_o, sn_o});
    $display("test overwrite %h done", c);
  endtask
  task automatic t_reject();
    wr_n = 0;
    sup = 0;
    rej(SOW_FEAT_OVERWRITE, 8'h01, SOW_RSN_NONE);
    sup = 1;
    rej(16'h0015, 8'h01, SOW_RSN_BADFEAT);
    chk("writes", 0, wr_n);
    $display("test reject done");
  endtask
  task automatic t_fail();
    wr_n = 0;
    inv = 0;
    fail_en = 1;
    cmd(SOW_FEAT_OVERWRITE, 8'h01);
    wait_idle();
    fail_en = 0;
    chk("flag", 0, sc_o[15]);
    rej(SOW_FEAT_OVERWRITE, 8'h11, SOW_RSN_UNSAN);
    cmd(SOW_FEAT_STATUS, 8'h00);
    sup = 0;
    rej(SOW_FEAT_OVERWRITE, 8'h01, SOW_RSN_UNSAN);
    sup = 1;
    run(8'h01, 256);
    wr_n = 0;
    fail_en = 1;
    cmd(SOW_FEAT_OVERWRITE, 8'h11);
    wait_idle();
    fail_en = 0;
    cmd(SOW_FEAT_STATUS, 8'h00);
    sup = 0;
    rej(SOW_FEAT_OVERWRITE, 8'h01, SOW_RSN_NONE);
    sup = 1;
    run(8'h01, 256);
    $display("test fail done");
  endtask
  task automatic t_freeze();
    cmd(SOW_FEAT_FREEZE, 8'h00);
    @(posedge clk) #2;
    chk("frozen", 1, sc_o[13]);
    rej(SOW_FEAT_OVERWRITE, 8'h01, SOW_RSN_FROZEN);
    @(posedge clk) #2;
    rstn = 0;
    @(posedge clk) #2;
    rstn = 1;
    chk("frozen", 0, sc_o[13]);
    chk("flag", 1, sc_o[15]);
    $display("test freeze done");
  endtask
  // ****************
  // write monitor, clock, timeout
  // ****************
  always @(posedge clk) begin
    if (mwr === 1'b1) begin
      chk("lba", wr_n[7:0], lba);
      chk("data", pat ^ {32{inv & wr_n[8]}}, mdata);
      wr_n <= wr_n + 1;
    end
  end
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    {rstn, por_n, go, fail_en, inv, op, sc, feat} = '0;
    {bad_count, check_count, wr_n, cyc} = '0;
    sup = 1;
    s_prev = 8'hA5;
    c_hi = 8'h3C;
    c_lo = 8'h96;
    s_cur = 8'h0F;
    pat = 32'hA53C_960F;
    repeat (6) @(posedge clk);
    #2;
    rstn = 1;
    por_n = 1;
    t_reject();
    run(8'h82, 512);
    run(8'h00, 4096);
    t_fail();
    t_freeze();
    summarize();
  end
endmodule
`default_nettype wire
